/* File: hw/period_timer.sv */
`timescale 1ns/10ps
`include "period_timer_params.svh"
module period_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic                               irq,
  output logic                               ssp_match,
  output period_timer_pkg::timebase_t        ccp_timebase
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (WIDTH != 8) begin : g_bad_width
    $error("period_timer supports WIDTH of 8 only");
  end

  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  logic        wr_q;
  logic        rd_q;
  logic [11:0] addr_q;
  logic [7:0]  count_q;
  logic [7:0]  period_q;
  period_timer_pkg::ctrl_t ctrl_q;
  logic [7:0]  flags_q;
  logic [7:0]  enables_q;
  logic [1:0]  qdiv_q;
  logic [3:0]  pre_q;
  logic [3:0]  post_q;
  logic        tick;
  logic        pre_done;
  logic        hit;
  logic        post_done;
  logic        wr_count;
  logic        wr_period;
  logic        wr_ctrl;
  logic        wr_flags;
  logic        wr_enables;
  logic [3:0]  pre_lim;

  // single cycle slave: every transfer completes in its first data phase cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 12'h000;
    end else if (hready) begin
      wr_q   <= hsel && htrans[1] && hwrite;
      rd_q   <= hsel && htrans[1] && !hwrite;
      addr_q <= haddr[11:0];
    end
  end

  // no wait states and always okay; a slower register file would stall here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // write strobes in the data phase
  assign wr_count   = wr_q && (addr_q == `PT_ADDR_COUNT);
  assign wr_period  = wr_q && (addr_q == `PT_ADDR_PERIOD);
  assign wr_ctrl    = wr_q && (addr_q == `PT_ADDR_CONTROL);
  assign wr_flags   = wr_q && (addr_q == `PT_ADDR_FLAGS);
  assign wr_enables = wr_q && (addr_q == `PT_ADDR_ENABLES);

  // read data registered at the address phase; unmapped reads as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[11:0])
        `PT_ADDR_COUNT:   hrdata <= {24'h000000, count_q};
        `PT_ADDR_PERIOD:  hrdata <= {24'h000000, period_q};
        `PT_ADDR_CONTROL: hrdata <= {24'h000000, 1'b0, ctrl_q};
        `PT_ADDR_FLAGS:   hrdata <= {24'h000000, flags_q};
        `PT_ADDR_ENABLES: hrdata <= {24'h000000, enables_q};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // period, reloadable by software at any time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_q <= `PT_RST_PERIOD;
    end else if (wr_period) begin
      period_q <= hwdata[7:0];
    end
  end

  // control; bit 7 is not stored and reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= period_timer_pkg::ctrl_t'(`PT_RST_CONTROL);
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata[6:0];
    end
  end

  // all eight mask bits kept so software reads back what it wrote
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enables_q <= `PT_RST_ENABLES;
    end else if (wr_enables) begin
      enables_q <= hwdata[7:0];
    end
  end

  // ----------------------------------------
  // instruction clock and prescaler
  // ----------------------------------------
  // quarter rate enable; free running so the instruction phase is not disturbed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qdiv_q <= 2'h0;
    end else begin
      qdiv_q <= qdiv_q + 2'h1;
    end
  end
  assign tick = (qdiv_q == `PT_INSTR_DIV) && ctrl_q.run;

  // prescale limit; both upper codes give divide by sixteen
  always_comb begin
    case (ctrl_q.pre_sel)
      2'h0:    pre_lim = `PT_PRE_DIV1;
      2'h1:    pre_lim = `PT_PRE_DIV4;
      default: pre_lim = `PT_PRE_DIV16;
    endcase
  end
  assign pre_done = tick && (pre_q >= pre_lim);

  // prescaler; cleared by count or control writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= 4'h0;
    end else if (wr_count || wr_ctrl) begin
      pre_q <= 4'h0;
    end else if (pre_done) begin
      pre_q <= 4'h0;
    end else if (tick) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // ----------------------------------------
  // counter and period match
  // ----------------------------------------
  assign hit = pre_done && (count_q == period_q);

  // software write wins over a coincident increment
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= `PT_RST_COUNT;
    end else if (wr_count) begin
      count_q <= hwdata[7:0];
    end else if (hit) begin
      count_q <= 8'h00;
    end else if (pre_done) begin
      count_q <= count_q + 8'h01;
    end
  end

  // postscaler counts match events
  assign post_done = hit && (post_q == ctrl_q.post_sel);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_q <= 4'h0;
    end else if (wr_count || wr_ctrl) begin
      post_q <= 4'h0;
    end else if (post_done) begin
      post_q <= 4'h0;
    end else if (hit) begin
      post_q <= post_q + 4'h1;
    end
  end

  // ----------------------------------------
  // interrupt flags
  // ----------------------------------------
  // write one to clear; a coincident set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= `PT_RST_FLAGS;
    end else begin
      flags_q[`PT_FLAG_BIT] <= post_done ||
        (flags_q[`PT_FLAG_BIT] && !(wr_flags && hwdata[`PT_FLAG_BIT]));
    end
  end

  // registered so the interrupt pin comes straight from a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_q & enables_q);
    end
  end

  // ----------------------------------------
  // time base outputs, one cycle after the event
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ssp_match    <= 1'b0;
      ccp_timebase <= '0;
    end else begin
      ssp_match          <= hit;
      ccp_timebase.match <= hit;
      ccp_timebase.count <= count_q;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_hit_seen;
    hit ##1 ssp_match;
  endsequence

  // bus side and register loads
  a_read_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_q |-> hreadyout && !hresp)
    else $error("read data phase not okay");
  a_count_load: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_count |=> count_q == $past(hwdata[7:0]))
    else $error("count write not taken");
  a_period_load: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_period |=> period_q == $past(hwdata[7:0]))
    else $error("period write not taken");

  // counter and scalers
  a_match_wraps: assert property (@(posedge hclk) disable iff (!hresetn)
    hit && !wr_count |=> count_q == 8'h00)
    else $error("count did not wrap on match");
  a_incr_step: assert property (@(posedge hclk) disable iff (!hresetn)
    pre_done && !hit && !wr_count |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not increment");
  a_stop_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_q.run && !wr_count |=> $stable(count_q))
    else $error("count moved while stopped");
  a_stop_prescale: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_q.run && !wr_count && !wr_ctrl |=> $stable(pre_q))
    else $error("prescaler moved while stopped");
  a_ctrl_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> count_q == $past(count_q) || $past(pre_done))
    else $error("control write changed count");
  a_scalers_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_count || wr_ctrl |=> pre_q == 4'h0 && post_q == 4'h0)
    else $error("scalers not cleared by write");
  a_div1_every: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && ctrl_q.pre_sel == 2'h0 |-> pre_done)
    else $error("divide by one missed a tick");
  a_post_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    post_q <= ctrl_q.post_sel)
    else $error("postscaler ran past its ratio");

  // flags and outputs
  a_flag_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    post_done |=> flags_q[`PT_FLAG_BIT])
    else $error("match flag not set");
  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    flags_q[`PT_FLAG_BIT] && !wr_flags |=> flags_q[`PT_FLAG_BIT])
    else $error("match flag dropped without software clear");
  a_flag_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    flags_q[`PT_FLAG_BIT] && wr_flags && hwdata[`PT_FLAG_BIT] && !post_done
      |=> !flags_q[`PT_FLAG_BIT])
    else $error("match flag not cleared by write of one");
  a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 irq == $past(|(flags_q & enables_q)))
    else $error("irq does not follow flags and enables");
  a_ssp_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    hit |-> s_hit_seen)
    else $error("serial port match pulse missing");
  a_ssp_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    !hit |=> !ssp_match)
    else $error("serial port pulse without a match");
  a_timebase_count: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 ccp_timebase.count == $past(count_q))
    else $error("time base count does not follow counter");

endmodule

/* File: hw/period_timer_params.svh */
`ifndef PERIOD_TIMER_PARAMS_SVH
`define PERIOD_TIMER_PARAMS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PT_ADDR_COUNT   12'h000
`define PT_ADDR_PERIOD  12'h004
`define PT_ADDR_CONTROL 12'h008
`define PT_ADDR_FLAGS   12'h00C
`define PT_ADDR_ENABLES 12'h010
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PT_FLAG_BIT     1
`define PT_RUN_BIT      2
`define PT_POST_LSB     3
`define PT_CTRL_MASK    8'h7F
`define PT_RST_COUNT    8'h00
`define PT_RST_PERIOD   8'hFF
`define PT_RST_CONTROL  8'h00
`define PT_RST_FLAGS    8'h00
`define PT_RST_ENABLES  8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define PT_INSTR_DIV    2'h3
`define PT_PRE_DIV1     4'h0
`define PT_PRE_DIV4     4'h3
`define PT_PRE_DIV16    4'hF
`endif

/* File: hw/period_timer_pkg.sv */
package period_timer_pkg;
  typedef struct packed {
    logic [3:0] post_sel;
    logic       run;
    logic [1:0] pre_sel;
  } ctrl_t;
  typedef struct packed {
    logic [7:0] count;
    logic       match;
  } timebase_t;
endpackage

/* File: tb/period_timer_8bit_pre_post_scaler_test.sv */
`timescale 1ns/10ps
`include "period_timer_params.svh"
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module period_timer_8bit_pre_post_scaler_test;
  logic                        hclk = 1'b0;
  logic                        hresetn = 1'b0;
  logic                        hsel = 1'b0;
  logic                        hwrite = 1'b0;
  logic [1:0]                  htrans = 2'h0;
  logic [2:0]                  hsize = 3'h2;
  logic [31:0]                 haddr = 32'h0;
  logic [31:0]                 hwdata = 32'h0;
  logic [31:0]                 hrdata;
  logic                        hreadyout;
  logic                        hresp;
  logic                        irq;
  logic                        ssp_match;
  period_timer_pkg::timebase_t ccp_timebase;
  int                          n_fail = 0;
  int                          cmp_count = 0;
  // ----------------------------------------
  // clock and design
  // ----------------------------------------
  always #10 hclk = ~hclk;
  period_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .ssp_match(ssp_match),
    .ccp_timebase(ccp_timebase));
  // ----------------------------------------
  // bus and wait helpers
  // ----------------------------------------
  task end_of_test;
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one edge with hready high; a stuck slave ends the run
  task bus_edge;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin n_fail++; end_of_test(); end
      @(posedge hclk);
    end
  endtask
  task bus_xfer(input logic [11:0] a, input logic wr, input logic [7:0] d,
                output logic [31:0] q);
    haddr <= {20'h0, a};
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    bus_edge();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    bus_edge();
    q = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus_xfer(a, 1'b1, d, q);
  endtask
  task chk_reg(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(a, 1'b0, 8'h00, q);
    `CHK(nm, exp, q)
    `CHK("okay response", 1'b0, hresp)
  endtask
  // cycles until the next pre-postscaler match pulse
  task wait_match(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 3000) begin n_fail++; end_of_test(); end
    end while (ssp_match !== 1'b1);
    `CHK("timebase match", 1'b1, ccp_timebase.match)
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    chk_reg("count", `PT_ADDR_COUNT, 32'h00);
    chk_reg("period", `PT_ADDR_PERIOD, 32'hFF);
    chk_reg("control", `PT_ADDR_CONTROL, 32'h00);
    chk_reg("flags", `PT_ADDR_FLAGS, 32'h00);
    chk_reg("enables", `PT_ADDR_ENABLES, 32'h00);
    chk_reg("unmapped", 12'h020, 32'h00);
  endtask
  // stopped timer: registers hold, control write keeps the count
  task t_regs;
    wr(`PT_ADDR_PERIOD, 8'hA5);
    chk_reg("period", `PT_ADDR_PERIOD, 32'hA5);
    wr(`PT_ADDR_CONTROL, 8'hFB);
    chk_reg("control", `PT_ADDR_CONTROL, 32'h7B);
    wr(`PT_ADDR_COUNT, 8'h3C);
    wr(`PT_ADDR_CONTROL, 8'h00);
    chk_reg("count", `PT_ADDR_COUNT, 32'h3C);
    repeat (40) @(posedge hclk);
    chk_reg("count", `PT_ADDR_COUNT, 32'h3C);
    `CHK("timebase count", 8'h3C, ccp_timebase.count)
  endtask
  // match period for every prescale code with period 3
  task t_prescale;
    int n;
    int code;
    wr(`PT_ADDR_PERIOD, 8'h03);
    for (code = 0; code < 4; code++) begin
      wr(`PT_ADDR_CONTROL, 8'h04 | 8'(code));
      wait_match(n);
      wait_match(n);
      `CHK("match interval", 4 * 4 * (code == 0 ? 1 : code == 1 ? 4 : 16), n)
    end
  endtask
  // matches counted before the interrupt, then mask and clear
  task t_post(input logic [3:0] sel);
    int n;
    wr(`PT_ADDR_CONTROL, 8'h00);
    wr(`PT_ADDR_PERIOD, 8'h01);
    wr(`PT_ADDR_FLAGS, 8'h02);
    wr(`PT_ADDR_ENABLES, 8'h02);
    wr(`PT_ADDR_COUNT, 8'h00);
    wr(`PT_ADDR_CONTROL, {1'b0, sel, 3'b100});
    n = 0;
    for (int i = 0; i < 400 && irq !== 1'b1; i++) begin
      @(posedge hclk);
      if (ssp_match === 1'b1) n++;
    end
    if (irq !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
    `CHK("irq raised", 1'b1, irq)
    `CHK("matches before irq", int'(sel) + 1, n)
    wr(`PT_ADDR_CONTROL, 8'h00);
    wr(`PT_ADDR_ENABLES, 8'h00);
    repeat (2) @(posedge hclk);
    `CHK("masked irq", 1'b0, irq)
    chk_reg("flags", `PT_ADDR_FLAGS, 32'h02);
    wr(`PT_ADDR_FLAGS, 8'h02);
    chk_reg("flags", `PT_ADDR_FLAGS, 32'h00);
  endtask
  // a count write restarts the divide-by-16 prescaler
  task t_clear;
    int n;
    wr(`PT_ADDR_PERIOD, 8'hFF);
    wr(`PT_ADDR_CONTROL, 8'h06);
    repeat (100) @(posedge hclk);
    wr(`PT_ADDR_COUNT, 8'h10);
    n = 0;
    while (ccp_timebase.count !== 8'h11 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 300) begin
      n_fail++;
      end_of_test();
    end
    `CHK("first step after write", 1'b1, n > 56 && n < 70)
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_regs();
    t_prescale();
    t_post(4'h0);
    t_post(4'h2);
    t_post(4'hF);
    t_clear();
    // reset in mid-run while the timer is counting
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    end_of_test();
  end
endmodule
